/* File: peg_electronic_gear.sv */
`timescale 1ns/1ps
module peg_electronic_gear
(
    input  wire logic              clk_in,
    input  wire logic              arst_n_in,
    input  wire logic [31:0]       enc_increments_in,
    input  wire logic [31:0]       enc_motor_rev_in,
    input  wire logic              cfg_wr_in,
    input  wire peg_pkg::peg_gear_cfg_t cfg_in,
    output peg_pkg::peg_gear_cfg_t cfg_backup_out,
    input  wire logic              cmd_valid_in,
    input  wire peg_pkg::peg_cmd_t cmd_in,
    output logic                   cmd_ready_out,
    output logic                   demand_valid_out,
    output peg_pkg::peg_cmd_t      demand_out,
    output logic [31:0]            ratio_num_out,
    output logic [31:0]            ratio_den_out,
    output logic                   ratio_ok_out,
    output logic                   improper_operation_fault_out,
    input  wire logic              fault_clr_in
);

    typedef enum {st_idle, st_gcd, st_div_num, st_div_den, st_check, st_scale} peg_state_t;

    // One restoring division step on a 65-bit partial remainder
    function automatic logic [128:0] div_step(input logic [64:0] rem, input logic [63:0] quo,
                                              input logic [63:0] dvs);
        logic [64:0] sh;
        sh = {rem[63:0], quo[63]};
        if (sh >= {1'b0, dvs})
            div_step = {sh - {1'b0, dvs}, quo[62:0], 1'b1};
        else
            div_step = {sh, quo[62:0], 1'b0};
    endfunction : div_step

    peg_pkg::peg_gear_cfg_t cfg_q, cfg_d;
    logic [31:0] enc_seen_q, enc_seen_d, mrev_seen_q, mrev_seen_d;
    logic        pend_q, pend_d, fault_q, fault_d;

    peg_state_t  state_q, state_d;
    logic [63:0] num_q, num_d, den_q, den_d, ga_q, ga_d, gb_q, gb_d, quo_q, quo_d, dvs_q, dvs_d;
    logic [6:0]  gk_q, gk_d, cnt_q, cnt_d;
    logic [64:0] rem_q, rem_d;
    logic [31:0] rnum_q, rnum_d, rden_q, rden_d;
    logic        rok_q, rok_d, neg_q, neg_d, ovld_q, ovld_d, take_calc, take_cmd, fault_set;
    peg_pkg::peg_mode_t mode_q, mode_d;
    peg_pkg::peg_cmd_t  out_q, out_d;

    logic [95:0] n96, d96;
    logic [128:0] stepv;
    logic [73:0] num_k, den_k;
    logic [31:0] mag;

    // ratio terms, increments taken from the encoder side only
    assign n96 = 96'(enc_increments_in) * 96'(cfg_q.motor_shaft_rev) * 96'(cfg_q.feed_shaft_rev);
    assign d96 = 96'(enc_motor_rev_in) * 96'(cfg_q.driving_shaft_rev) * 96'(cfg_q.feed);
    assign stepv = div_step(rem_q, quo_q, dvs_q);
    assign num_k = 74'(num_q) * 74'(peg_pkg::RATIO_LIMIT);
    assign den_k = 74'(den_q) * 74'(peg_pkg::RATIO_LIMIT);
    assign mag = cmd_in.pos[31] ? 32'(-cmd_in.pos) : 32'(cmd_in.pos);

    assign take_calc = (state_q == st_idle) && pend_q;
    // all four position modes are accepted alike
    assign cmd_ready_out = (state_q == st_idle) && !pend_q && rok_q;
    assign take_cmd = cmd_ready_out && cmd_valid_in;

    always_comb
    begin
        state_d = state_q;
        num_d = num_q;
        den_d = den_q;
        ga_d = ga_q;
        gb_d = gb_q;
        gk_d = gk_q;
        cnt_d = cnt_q;
        rem_d = rem_q;
        quo_d = quo_q;
        dvs_d = dvs_q;
        rnum_d = rnum_q;
        rden_d = rden_q;
        rok_d = rok_q;
        neg_d = neg_q;
        mode_d = mode_q;
        out_d = out_q;
        ovld_d = 1'b0;
        fault_set = 1'b0;
        case (state_q)
            st_idle:
            begin
                if (take_calc)
                begin
                    if (n96[95:64] != 32'h0000_0000 || d96[95:64] != 32'h0000_0000
                        || n96 == 96'h0 || d96 == 96'h0)
                        fault_set = 1'b1;
                    else
                    begin
                        num_d = n96[63:0];
                        den_d = d96[63:0];
                        ga_d = n96[63:0];
                        gb_d = d96[63:0];
                        gk_d = 7'h00;
                        state_d = st_gcd;
                    end
                end
                else if (take_cmd)
                begin
                    // magnitude times numerator, then divided by denominator
                    rem_d = 65'h0;
                    quo_d = 64'(mag) * 64'(rnum_q);
                    dvs_d = 64'(rden_q);
                    cnt_d = peg_pkg::DIV_STEPS;
                    neg_d = cmd_in.pos[31];
                    mode_d = cmd_in.mode;
                    state_d = st_scale;
                end
            end
            st_gcd:
            begin
                if (ga_q == gb_q)
                begin
                    rem_d = 65'h0;
                    quo_d = num_q;
                    dvs_d = ga_q << gk_q;
                    cnt_d = peg_pkg::DIV_STEPS;
                    state_d = st_div_num;
                end
                else if (!ga_q[0] && !gb_q[0])
                begin
                    ga_d = ga_q >> 1;
                    gb_d = gb_q >> 1;
                    gk_d = gk_q + 7'h01;
                end
                else if (!ga_q[0])
                    ga_d = ga_q >> 1;
                else if (!gb_q[0])
                    gb_d = gb_q >> 1;
                else if (ga_q > gb_q)
                    ga_d = (ga_q - gb_q) >> 1;
                else
                    gb_d = (gb_q - ga_q) >> 1;
            end
            st_div_num, st_div_den, st_scale:
            begin
                rem_d = stepv[128:64];
                quo_d = stepv[63:0];
                cnt_d = cnt_q - 7'h01;
                if (cnt_q == 7'h01)
                begin
                    if (state_q == st_div_num)
                    begin
                        num_d = stepv[63:0];
                        rem_d = 65'h0;
                        quo_d = den_q;
                        cnt_d = peg_pkg::DIV_STEPS;
                        state_d = st_div_den;
                    end
                    else if (state_q == st_div_den)
                    begin
                        den_d = stepv[63:0];
                        state_d = st_check;
                    end
                    else
                    begin
                        out_d.mode = mode_q;
                        // Saturate to the signed 32-bit demand range
                        if (neg_q)
                            out_d.pos = (stepv[63:0] > peg_pkg::NEG_MAX_MAG) ? 32'sh8000_0000
                                      : -$signed(stepv[31:0]);
                        else
                            out_d.pos = (stepv[63:0] > peg_pkg::POS_MAX_MAG) ? 32'sh7FFF_FFFF
                                      : $signed(stepv[31:0]);
                        ovld_d = 1'b1;
                        state_d = st_idle;
                    end
                end
            end
            st_check:
            begin
                state_d = st_idle;
                if (74'(num_q) > den_k)
                begin
                    rnum_d = peg_pkg::RATIO_LIMIT;
                    rden_d = peg_pkg::SHIP_REV;
                    rok_d = 1'b1;
                    fault_set = 1'b1;
                end
                else if (num_k < 74'(den_q))
                begin
                    rnum_d = peg_pkg::SHIP_REV;
                    rden_d = peg_pkg::RATIO_LIMIT;
                    rok_d = 1'b1;
                    fault_set = 1'b1;
                end
                // reduced terms wider than 32 bits
                else if (num_q[63:32] != 32'h0000_0000 || den_q[63:32] != 32'h0000_0000)
                    fault_set = 1'b1;
                else
                begin
                    rnum_d = num_q[31:0];
                    rden_d = den_q[31:0];
                    rok_d = 1'b1;
                end
            end
            default:
                state_d = st_idle;
        endcase
    end

    always_comb
    begin
        cfg_d = cfg_q;
        // host restores or rewrites the backed-up gear entries here
        if (cfg_wr_in)
            cfg_d = cfg_in;
        enc_seen_d = enc_increments_in;
        mrev_seen_d = enc_motor_rev_in;
        pend_d = (pend_q && !take_calc) || cfg_wr_in || (enc_seen_q != enc_increments_in)
                 || (mrev_seen_q != enc_motor_rev_in);
        // Set wins over clear
        fault_d = (fault_q && !fault_clr_in) || fault_set;
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cfg_q <= peg_pkg::SHIP_CFG;
            enc_seen_q <= 32'h0000_0000;
            mrev_seen_q <= 32'h0000_0000;
            pend_q <= 1'b1;
            fault_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            enc_seen_q <= enc_seen_d;
            mrev_seen_q <= mrev_seen_d;
            pend_q <= pend_d;
            fault_q <= fault_d;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_q <= st_idle;
            num_q <= 64'h0;
            den_q <= 64'h0;
            ga_q <= 64'h0;
            gb_q <= 64'h0;
            gk_q <= 7'h00;
            cnt_q <= 7'h00;
            rem_q <= 65'h0;
            quo_q <= 64'h0;
            dvs_q <= 64'h0;
            rnum_q <= peg_pkg::SHIP_REV;
            rden_q <= peg_pkg::SHIP_REV;
            rok_q <= 1'b0;
            neg_q <= 1'b0;
            mode_q <= peg_pkg::profile_position_mode;
            out_q <= '0;
            ovld_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            num_q <= num_d;
            den_q <= den_d;
            ga_q <= ga_d;
            gb_q <= gb_d;
            gk_q <= gk_d;
            cnt_q <= cnt_d;
            rem_q <= rem_d;
            quo_q <= quo_d;
            dvs_q <= dvs_d;
            rnum_q <= rnum_d;
            rden_q <= rden_d;
            rok_q <= rok_d;
            neg_q <= neg_d;
            mode_q <= mode_d;
            out_q <= out_d;
            ovld_q <= ovld_d;
        end
    end

    // gear entries exposed for nonvolatile backup
    assign cfg_backup_out = cfg_q;
    assign demand_valid_out = ovld_q;
    assign demand_out = out_q;
    assign ratio_num_out = rnum_q;
    assign ratio_den_out = rden_q;
    assign ratio_ok_out = rok_q;
    assign improper_operation_fault_out = fault_q;
endmodule : peg_electronic_gear

/* File: peg_pkg.sv */
// Operation
// - Position commands are taken in profile, cyclic synchronous, interpolated and homing modes.
// - Internal demand in pulses equals host demand times the electronic gear ratio.
// - Ratio is held between 1/1000 and 1000; clamping raises the fault.
// - Numerator or denominator above 64 bits during calculation raises the fault.
// - Reduced numerator or denominator above 32 bits raises the fault.
// - Encoder increments come from the fitted encoder, never from the host.
// - Default feed gives unity ratio with a 20-bit-per-revolution encoder.
// - The four gear entries are offered for nonvolatile backup and restore.
// - Revolution entries ship as one, so feed equals pulses per revolution.
package peg_pkg;

    localparam logic [31:0] RATIO_LIMIT   = 32'h0000_03E8;
    localparam logic [31:0] SHIP_REV      = 32'h0000_0001;
    localparam logic [31:0] DEFAULT_FEED  = 32'h0010_0000;
    localparam logic [6:0]  DIV_STEPS     = 7'h40;
    localparam logic [63:0] POS_MAX_MAG   = 64'h0000_0000_7FFF_FFFF;
    localparam logic [63:0] NEG_MAX_MAG   = 64'h0000_0000_8000_0000;

    typedef enum logic [1:0] {
        profile_position_mode,
        cyclic_sync_position_mode,
        interpolated_position_mode,
        homing_mode
    } peg_mode_t;

    typedef struct packed {
        logic [31:0] motor_shaft_rev;
        logic [31:0] driving_shaft_rev;
        logic [31:0] feed;
        logic [31:0] feed_shaft_rev;
    } peg_gear_cfg_t;

    typedef struct packed {
        peg_mode_t          mode;
        logic signed [31:0] pos;
    } peg_cmd_t;

    localparam peg_gear_cfg_t SHIP_CFG = '{
        motor_shaft_rev:   SHIP_REV,
        driving_shaft_rev: SHIP_REV,
        feed:              DEFAULT_FEED,
        feed_shaft_rev:    SHIP_REV
    };

endpackage : peg_pkg

/* File: peg_electronic_gear_sva.sv */
`timescale 1ns/1ps
module peg_electronic_gear_sva
(
    input wire logic                   clk_in,
    input wire logic                   arst_n_in,
    input wire logic                   cfg_wr_in,
    input wire peg_pkg::peg_gear_cfg_t cfg_in,
    input wire peg_pkg::peg_gear_cfg_t cfg_backup_out,
    input wire logic                   cmd_valid_in,
    input wire peg_pkg::peg_cmd_t      cmd_in,
    input wire logic                   cmd_ready_out,
    input wire logic                   demand_valid_out,
    input wire peg_pkg::peg_cmd_t      demand_out,
    input wire logic [31:0]            ratio_num_out,
    input wire logic [31:0]            ratio_den_out,
    input wire logic                   ratio_ok_out,
    input wire logic                   improper_operation_fault_out,
    input wire logic                   fault_clr_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_take;
        cmd_valid_in && cmd_ready_out;
    endsequence
    sequence s_busy;
        !cmd_ready_out [*8];
    endsequence
    property p_lat; s_take |-> ##65 demand_valid_out; endproperty
    a_lat: assert property (p_lat) else $error("demand not after 65 cycles");
    property p_busy; s_take |=> s_busy; endproperty
    a_busy: assert property (p_busy) else $error("ready while dividing");
    property p_mode; demand_valid_out |-> demand_out.mode == $past(cmd_in.mode, 65); endproperty
    a_mode: assert property (p_mode) else $error("mode not passed on");
    property p_pulse; demand_valid_out |=> !demand_valid_out; endproperty
    a_pulse: assert property (p_pulse) else $error("demand valid too long");
    property p_range;
        ratio_ok_out |-> (64'(ratio_num_out) <= 64'(ratio_den_out) * 64'h3E8)
            && (64'(ratio_den_out) <= 64'(ratio_num_out) * 64'h3E8);
    endproperty
    a_range: assert property (p_range) else $error("ratio outside span");
    property p_sticky; improper_operation_fault_out && !fault_clr_in |=> improper_operation_fault_out; endproperty
    a_sticky: assert property (p_sticky) else $error("fault dropped");
    property p_noratio; !ratio_ok_out |-> !cmd_ready_out; endproperty
    a_noratio: assert property (p_noratio) else $error("ready without ratio");
    property p_load; cfg_wr_in |=> cfg_backup_out == $past(cfg_in); endproperty
    a_load: assert property (p_load) else $error("entries not loaded");
    property p_hold; !cfg_wr_in |=> $stable(cfg_backup_out); endproperty
    a_hold: assert property (p_hold) else $error("entries changed");
    property p_prio; cfg_wr_in |=> !cmd_ready_out; endproperty
    a_prio: assert property (p_prio) else $error("ready during recalc");
endmodule : peg_electronic_gear_sva
bind peg_electronic_gear peg_electronic_gear_sva i_sva (.clk_in, .arst_n_in, .cfg_wr_in, .cfg_in,
    .cfg_backup_out, .cmd_valid_in, .cmd_in, .cmd_ready_out, .demand_valid_out, .demand_out,
    .ratio_num_out, .ratio_den_out, .ratio_ok_out, .improper_operation_fault_out, .fault_clr_in);

/* File: peg_host_model.sv */
`timescale 1ns/1ps
module peg_host_model
(
    input  wire logic              clk_in,
    input  wire logic              go_in,
    input  wire peg_pkg::peg_cmd_t req_in,
    input  wire logic              ready_in,
    output logic                   valid_out,
    output peg_pkg::peg_cmd_t      cmd_out
);
    logic taken;
    logic start;
    initial
    begin
        valid_out = 1'b0;
        cmd_out = '0;
    end
    always @(posedge clk_in)
    begin
        taken = valid_out && ready_in;
        start = go_in;
    end
    // host sends in-range positions, held until taken
    always @(negedge clk_in)
    begin
        if (start)
        begin
            valid_out <= 1'b1;
            cmd_out <= req_in;
        end
        else if (taken)
        begin
            valid_out <= 1'b0;
            cmd_out <= ~cmd_out;
        end
    end
endmodule : peg_host_model

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    logic                   clk_in;
    logic                   arst_n_in;
    logic [31:0]            enc_inc;
    logic [31:0]            enc_rev;
    logic                   cfg_wr;
    logic                   fault_clr;
    logic                   go;
    logic                   cmd_valid;
    logic                   ready;
    logic                   dv;
    logic                   ok;
    logic                   fault;
    logic [31:0]            num;
    logic [31:0]            den;
    peg_pkg::peg_gear_cfg_t cfg;
    peg_pkg::peg_gear_cfg_t bkp;
    peg_pkg::peg_cmd_t      req;
    peg_pkg::peg_cmd_t      cmd;
    peg_pkg::peg_cmd_t      dem;
    int                     miscompares;
    int                     checked;
    localparam logic [31:0] F = 32'h0010_0000;
    peg_electronic_gear i_dut
    (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .enc_increments_in(enc_inc), .enc_motor_rev_in(enc_rev),
        .cfg_wr_in(cfg_wr), .cfg_in(cfg), .cfg_backup_out(bkp), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
        .cmd_ready_out(ready), .demand_valid_out(dv), .demand_out(dem), .ratio_num_out(num),
        .ratio_den_out(den), .ratio_ok_out(ok), .improper_operation_fault_out(fault), .fault_clr_in(fault_clr)
    );
    peg_host_model i_host
    (
        .clk_in(clk_in), .go_in(go), .req_in(req), .ready_in(ready), .valid_out(cmd_valid), .cmd_out(cmd)
    );
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task stop_test;
        $display("Compared %0d, mismatched %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    task chk(input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task wait_rdy;
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 1000)
        begin
            @(negedge clk_in);
            n++;
        end
        chk(ready, 1'b1);
    endtask : wait_rdy
    task set_cfg(input peg_pkg::peg_gear_cfg_t c);
        cfg = c;
        cfg_wr = 1'b1;
        @(negedge clk_in);
        cfg_wr = 1'b0;
        @(negedge clk_in);
        wait_rdy();
        chk(bkp, c);
    endtask : set_cfg
    task chk_ratio(input logic [31:0] n, input logic [31:0] d, input logic f);
        chk({num, den, ok, fault}, {n, d, 1'b1, f});
        @(negedge clk_in);
        chk(fault, f);
        fault_clr = 1'b1;
        @(negedge clk_in);
        fault_clr = 1'b0;
        chk(fault, 1'b0);
    endtask : chk_ratio
    task do_cmd(input peg_pkg::peg_mode_t m, input logic signed [31:0] p, input logic signed [31:0] e);
        int n;
        req = '{mode: m, pos: p};
        go = 1'b1;
        @(negedge clk_in);
        go = 1'b0;
        n = 0;
        do
        begin
            @(posedge clk_in);
            #1;
            n++;
        end while (dv !== 1'b1 && n < 200);
        chk(dv, 1'b1);
        chk(n, 65);
        chk(dem, {m, e});
        @(negedge clk_in);
    endtask : do_cmd
    task t_ship;
        wait_rdy();
        chk(bkp, peg_pkg::SHIP_CFG);
        chk_ratio(32'h1, 32'h1, 1'b0);
    endtask : t_ship
    task t_gear;
        set_cfg('{32'h3, 32'h2, F, 32'h1});
        chk_ratio(32'h3, 32'h2, 1'b0);
        for (int m = 0; m < 4; m++)
            do_cmd(peg_pkg::peg_mode_t'(m[1:0]), -32'sh7, -32'shA);
        do_cmd(peg_pkg::homing_mode, 32'h5, 32'h7);
    endtask : t_gear
    task t_clamp;
        set_cfg('{32'h1388, 32'h1, F, 32'h1});
        chk_ratio(32'h3E8, 32'h1, 1'b1);
        do_cmd(peg_pkg::cyclic_sync_position_mode, 32'h8000_0000, 32'h8000_0000);
        set_cfg('{32'h1, 32'h1388, F, 32'h1});
        chk_ratio(32'h1, 32'h3E8, 1'b1);
        do_cmd(peg_pkg::profile_position_mode, 32'h7FFF_FFFF, 32'h0020_C49B);
    endtask : t_clamp
    task t_fit;
        set_cfg('{32'hFFFF_FFFF, 32'hFFFF_FFFD, F, 32'h3});
        chk_ratio(32'h1, 32'h3E8, 1'b1);
        set_cfg('{32'hFFFF_FFFF, 32'h1, F, 32'hFFFF_FFFF});
        chk_ratio(32'h1, 32'h3E8, 1'b1);
    endtask : t_fit
    task t_enc;
        set_cfg(peg_pkg::SHIP_CFG);
        chk_ratio(32'h1, 32'h1, 1'b0);
        enc_inc = 32'h0002_0000;
        @(negedge clk_in);
        @(negedge clk_in);
        wait_rdy();
        chk_ratio(32'h1, 32'h8, 1'b0);
        enc_rev = 32'h0000_0002;
        @(negedge clk_in);
        @(negedge clk_in);
        wait_rdy();
        chk_ratio(32'h1, 32'h10, 1'b0);
    endtask : t_enc
    initial
    begin
        #500000;
        miscompares++;
        stop_test();
    end
    initial
    begin
        arst_n_in = 1'b0;
        enc_inc = F;
        enc_rev = 32'h0000_0001;
        cfg_wr = 1'b0;
        fault_clr = 1'b0;
        go = 1'b0;
        cfg = peg_pkg::SHIP_CFG;
        req = '0;
        miscompares = 0;
        checked = 0;
        repeat (8) @(negedge clk_in);
        arst_n_in = 1'b1;
        t_ship();
        t_gear();
        t_clamp();
        t_fit();
        t_enc();
        stop_test();
    end
endmodule : tb
